// [hw/sps_pixel_port.sv]
// Pixel output and synchronisation port: row/frame timing, strobes, standby.
// Assumes pixel words arrive from the ADC path on pix_data_i each cycle;
// pins are plain in/out/enable triples resolved outside.
// Operation
// - Frame sync low pulse resets row, column counters in slave mode
// - Frame sync held low keeps standby in slave mode
// - Undriven frame sync reads inactive high
// - Frame valid high during whole frame readout
// - Row valid high exactly while pixels present
// - Master mode expose high during integration
// - Mode setting turns strobe pins in/out
// - Pixel word ten bits, bit nine MSB
// - Pixels change on falling clock edge
// - Row lasts 671 cycles without blanking
// - Asynchronous active-low reset, at least 200 ns
// - Row valid rises 2 cycles after frame
`timescale 1ns/1ps
module sps_pixel_port
    import sps_pkg::*;
#(
    parameter int ROWS     = SPS_ROWS,
    parameter int EXP_ROWS = SPS_EXP_ROWS
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rstn_i,
    input  wire sps_pkg::sps_mode_e   mode_i,
    input  wire logic [SPS_PIX_W-1:0] pix_data_i,
    input  wire logic                 frame_sync_n_i,
    input  wire logic                 frame_sync_pu_en_i,
    input  wire logic                 expose_i,
    output logic [SPS_PIX_W-1:0]      pix_data_o,
    output logic                      frame_valid_o,
    output logic                      frame_valid_oe_o,
    output logic                      row_valid_o,
    output logic                      row_valid_oe_o,
    output logic                      expose_o,
    output logic                      expose_oe_o,
    output logic                      standby_o
);
    import sps_pkg::*;

    localparam int COL_W = $clog2(SPS_ROW_CYCLES + 1);
    localparam int ROW_W = $clog2(ROWS + EXP_ROWS + 1);
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(SPS_ROW_CYCLES - 1);
    localparam logic [COL_W-1:0] COL_RV_ON = COL_W'(SPS_ROW_DELAY + SPS_FV_TO_RV - 1);
    localparam logic [COL_W-1:0] COL_RV_OFF = COL_W'(SPS_ROW_DELAY + SPS_FV_TO_RV - 1
                                                      + SPS_ROW_PIXELS);
    localparam logic [ROW_W-1:0] ROW_EXP_END = ROW_W'(EXP_ROWS);
    localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(EXP_ROWS + ROWS - 1);

    if (ROWS < 1 || EXP_ROWS < 1) begin : g_bad_cfg
        $error("sps_pixel_port: ROWS and EXP_ROWS must be at least one");
    end

    typedef enum logic [1:0] {
        SPS_ST_IDLE   = 2'h0,
        SPS_ST_EXPOSE = 2'h1,
        SPS_ST_READ   = 2'h3,
        SPS_ST_STBY   = 2'h2
    } sps_state_e;

    logic       fs_raw;
    logic       fs_s;
    logic       exp_s;
    logic       exp_prev_q;
    logic       fs_prev_q;
    logic [1:0] fs_low_q;
    logic [1:0] fs_low_d;
    sps_state_e st_q;
    sps_state_e st_d;
    logic [COL_W-1:0] col_q;
    logic [COL_W-1:0] col_d;
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] row_d;
    logic       rv_q;
    logic       rv_d;
    logic       fv_q;
    logic       fv_d;
    logic       expo_q;
    logic       expo_d;
    logic       drive;
    logic       row_end;
    logic       sync_rst;
    logic [COL_W-1:0] rv_per_q;
    logic [COL_W-1:0] rv_per_d;
    logic             rv_seen_q;
    logic             rv_seen_d;

    // Pull-up: an undriven pin reads high
    assign fs_raw = frame_sync_pu_en_i ? frame_sync_n_i : 1'b1;

    sps_sync2 #(.RST_VAL(1'b1)) u_fs_sync (
        .clk_i  (ref_clk_i),
        .rstn_i (rstn_i),
        .d_i    (fs_raw),
        .q_o    (fs_s)
    );

    sps_sync2 #(.RST_VAL(1'b0)) u_exp_sync (
        .clk_i  (ref_clk_i),
        .rstn_i (rstn_i),
        .d_i    (expose_i),
        .q_o    (exp_s)
    );

    // Strobe pins drive only outside slave mode
    assign drive            = (mode_i != SPS_MODE_SLAVE);
    assign frame_valid_oe_o = drive;
    assign row_valid_oe_o   = drive;
    assign expose_oe_o      = (mode_i == SPS_MODE_MASTER); // snapshot takes trigger in
    assign row_end          = (col_q == COL_LAST);
    // A sync pulse restarts counters only in slave mode
    assign sync_rst         = (mode_i == SPS_MODE_SLAVE) && !fs_s;

    // Low-time count of frame sync, saturating at three
    always_comb begin
        fs_low_d = fs_s ? 2'h0 : (fs_low_q == 2'h3 ? fs_low_q : fs_low_q + 2'h1);
    end

    // Sequencer: idle, exposure, readout, standby
    always_comb begin
        st_d   = st_q;
        col_d  = col_q;
        row_d  = row_q;
        fv_d   = 1'b0;
        rv_d   = 1'b0;
        expo_d = 1'b0;
        unique case (st_q)
            SPS_ST_IDLE: begin
                col_d = '0;
                row_d = '0;
                if (mode_i == SPS_MODE_MASTER ||
                    (mode_i == SPS_MODE_SNAPSHOT && exp_s && !exp_prev_q)) begin
                    st_d   = SPS_ST_EXPOSE;
                    expo_d = 1'b1; // integration starts with the row count
                end
            end
            SPS_ST_EXPOSE: begin
                expo_d = 1'b1;
                col_d  = row_end ? '0 : col_q + COL_W'(1);
                if (row_end) begin
                    row_d = row_q + ROW_W'(1);
                    if (row_q + ROW_W'(1) == ROW_EXP_END) begin
                        st_d   = SPS_ST_READ;
                        expo_d = 1'b0;
                        fv_d   = 1'b1;
                    end
                end
            end
            SPS_ST_READ: begin
                fv_d  = 1'b1;
                col_d = row_end ? '0 : col_q + COL_W'(1);
                // Row valid window: 666 pixel cycles then 5 low
                rv_d  = (col_d >= COL_RV_ON) && (col_d < COL_RV_OFF);
                if (row_end) begin
                    row_d = row_q + ROW_W'(1);
                    if (row_q == ROW_LAST) begin
                        st_d = SPS_ST_IDLE;
                        fv_d = 1'b0;
                        rv_d = 1'b0;
                    end
                end
            end
            SPS_ST_STBY: begin
                col_d = '0;
                row_d = '0;
            end
        endcase
        // Pulse resets counters; a held low parks in standby
        if (sync_rst) begin
            col_d = '0;
            row_d = '0;
            fv_d  = 1'b0;
            rv_d  = 1'b0;
            st_d  = (fs_low_d >= 2'(SPS_SYNC_MIN_CYC)) ? SPS_ST_STBY : SPS_ST_IDLE;
        end else if (st_q == SPS_ST_STBY) begin
            st_d = SPS_ST_IDLE; // resume after release
        end
        if (mode_i == SPS_MODE_SLAVE && st_d != SPS_ST_STBY)
            st_d = SPS_ST_IDLE;
    end

    // Cycles since row valid last rose; feeds only the row period
    always_comb begin
        rv_per_d  = (rv_per_q == '1) ? rv_per_q : rv_per_q + COL_W'(1);
        rv_seen_d = rv_seen_q && fv_d && !sync_rst;
        if (rv_d && !rv_q) begin
            rv_per_d  = '0;
            rv_seen_d = 1'b1;
        end
    end

    // Async reset loads constants only
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q       <= SPS_ST_IDLE;
            col_q      <= '0;
            row_q      <= '0;
            fv_q       <= 1'b0;
            rv_q       <= 1'b0;
            expo_q     <= 1'b0;
            exp_prev_q <= 1'b0;
            fs_prev_q  <= 1'b1;
            fs_low_q   <= 2'h0;
            rv_per_q   <= '0;
            rv_seen_q  <= 1'b0;
        end else begin
            st_q       <= st_d;
            col_q      <= col_d;
            row_q      <= row_d;
            fv_q       <= fv_d;
            rv_q       <= rv_d;
            expo_q     <= expo_d;
            exp_prev_q <= exp_s;
            fs_prev_q  <= fs_s;
            fs_low_q   <= fs_low_d;
            rv_per_q   <= rv_per_d;
            rv_seen_q  <= rv_seen_d;
        end
    end

    // Pixel word launched on falling edge; capture on next rising is safe
    always_ff @(negedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pix_data_o <= SPS_PIX_RST;
        end else begin
            pix_data_o[SPS_PIX_MSB:SPS_PIX_LSB] <= rv_q ? pix_data_i : SPS_PIX_RST;
        end
    end

    assign frame_valid_o = fv_q;
    assign row_valid_o   = rv_q;
    assign expose_o      = expo_q;
    assign standby_o     = (st_q == SPS_ST_STBY);

    // Row valid only inside frame valid
    AST_RV_IN_FV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rv_q |-> fv_q) else $error("row valid outside frame");
    // Frame start gives row valid two cycles later
    AST_FV_TO_RV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(fv_q) && !sync_rst |=> !rv_q ##1 (rv_q || sync_rst))
        else $error("row valid late after frame");
    // Rise-to-rise of row valid inside a frame is one full row time
    AST_ROW_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rv_d && !rv_q && rv_seen_q |-> rv_per_q == COL_LAST)
        else $error("row period not 671");
    // Row valid low gap spans at least four cycles
    AST_RV_GAP: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(rv_q) && fv_q |-> !rv_q [*4]) else $error("row gap short");
    // Expose never overlaps readout in master
    AST_EXP_NO_FV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        expo_q |-> !fv_q) else $error("expose during readout");
    // Sync low two cycles in slave forces standby
    AST_STBY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (mode_i == SPS_MODE_SLAVE) && !fs_s && !fs_prev_q |=> standby_o)
        else $error("no standby on held sync");
    // Sync release leaves standby next cycle
    AST_WAKE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        standby_o && fs_s |=> !standby_o) else $error("standby stuck");
    // Sync low in slave mode clears counters
    AST_SYNC_RST: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        sync_rst |=> (col_q == '0) && (row_q == '0)) else $error("counters not reset");
    // Slave mode drives neither the frame valid nor the expose strobe
    AST_DIR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (mode_i == SPS_MODE_SLAVE) |-> !frame_valid_oe_o && !expose_oe_o)
        else $error("strobe driven in slave");
endmodule : sps_pixel_port

// [hw/sps_sync2.sv]
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk_i; reset value is a parameter.
`timescale 1ns/1ps
module sps_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_q;
    logic sync_q;

    // First flop feeds only the second one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : sps_sync2

// [include/sps_pkg.sv]
// Package for the pixel sync port: modes, row timing and reset timing constants.
// Assumes a single 250 MHz reference clock shared by every design file.
package sps_pkg;

    // Operating modes chosen by the configuration setting
    typedef enum logic [1:0] {
        SPS_MODE_MASTER   = 2'h0,
        SPS_MODE_SNAPSHOT = 2'h1,
        SPS_MODE_SLAVE    = 2'h3
    } sps_mode_e;

    localparam int          SPS_PIX_W        = 10;
    localparam int          SPS_PIX_MSB      = 9;
    localparam int          SPS_PIX_LSB      = 0;
    localparam int          SPS_ROW_CYCLES   = 671;
    localparam int          SPS_ROW_DELAY    = 1;
    localparam int          SPS_ROW_GAP      = 4;
    localparam int          SPS_ROW_PIXELS   = SPS_ROW_CYCLES - SPS_ROW_DELAY - SPS_ROW_GAP;
    localparam int          SPS_FV_TO_RV     = 2;
    localparam int          SPS_ROWS         = 502;
    localparam int          SPS_EXP_ROWS     = 2;
    localparam int          SPS_SYNC_MIN_CYC = 2;
    localparam int          SPS_CLK_MHZ      = 250;
    localparam int          SPS_RST_MIN_NS   = 200;
    localparam int          SPS_RST_MIN_CYC  = (SPS_RST_MIN_NS * SPS_CLK_MHZ + 999) / 1000;
    localparam logic [SPS_PIX_W-1:0] SPS_PIX_RST = 10'h000;

endpackage : sps_pkg

// [tb/sps_host_model.sv]
// Frame grabber model: drives the sync and trigger pins and feeds ADC words.
// Assumes the bench calls its tasks at falling edges of the 250 MHz clock.
`timescale 1ns/1ps
module sps_host_model
    import sps_pkg::*;
#(
    parameter logic [SPS_PIX_W-1:0] PIX = 10'h2A5
) (
    input  wire logic                 clk_i,
    output logic [SPS_PIX_W-1:0]      pix_o,
    output logic                      fsync_n_o,
    output logic                      pu_en_o,
    output logic                      expose_o
);
    import sps_pkg::*;

    // Idle pins: sync inactive and driven, trigger low, fixed ADC word
    initial begin
        pix_o     = PIX;
        fsync_n_o = 1'b1;
        pu_en_o   = 1'b1;
        expose_o  = 1'b0;
    end

    // Released line shows the level opposite the pull-up, so only the pull-up keeps it idle
    always @(negedge clk_i) begin
        if (!pu_en_o) fsync_n_o <= 1'b0;
    end

    // Drive the sync pin to a level and keep it there
    task automatic set_sync(input logic v);
        pu_en_o   = 1'b1;
        fsync_n_o = v;
    endtask : set_sync

    // Shortest legal sync pulse
    task automatic sync_pulse();
        set_sync(1'b0);
        repeat (SPS_SYNC_MIN_CYC) @(negedge clk_i);
        fsync_n_o = 1'b1;
    endtask : sync_pulse

    // Stop driving the sync pin; the pad pull-up decides its level
    task automatic float_line(input logic on);
        pu_en_o = ~on;
    endtask : float_line

    // Snapshot trigger pulse, held long enough for the synchroniser
    task automatic trigger();
        expose_o = 1'b1;
        repeat (4) @(negedge clk_i);
        expose_o = 1'b0;
    endtask : trigger
endmodule : sps_host_model

// [tb/tb_sps_pixel_port.sv]
// Self-checking bench for the pixel sync port with a host model on the pins.
// Assumes ROWS is shortened to 2; outputs are sampled 1 ns after falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_sps_pixel_port;
    import sps_pkg::*;
    localparam int ROWS = 2;
    localparam logic [SPS_PIX_W-1:0] PIX = 10'h2A5;
    logic                 ref_clk_i = 1'b0;
    logic                 rstn_i    = 1'b0;
    sps_mode_e            mode_i    = SPS_MODE_MASTER;
    logic [SPS_PIX_W-1:0] pix_i;
    logic                 fs_n, pu_en, ex_i;
    logic [SPS_PIX_W-1:0] pix_o;
    logic                 fv, fv_oe, rv, rv_oe, ex_o, ex_oe, stby;
    int                   n_fail = 0;
    int                   n_checks = 0;

    sps_pixel_port #(.ROWS(ROWS), .EXP_ROWS(SPS_EXP_ROWS)) i_dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .mode_i(mode_i), .pix_data_i(pix_i),
        .frame_sync_n_i(fs_n), .frame_sync_pu_en_i(pu_en), .expose_i(ex_i),
        .pix_data_o(pix_o), .frame_valid_o(fv), .frame_valid_oe_o(fv_oe),
        .row_valid_o(rv), .row_valid_oe_o(rv_oe), .expose_o(ex_o),
        .expose_oe_o(ex_oe), .standby_o(stby));

    sps_host_model #(.PIX(PIX)) i_host (.clk_i(ref_clk_i), .pix_o(pix_i),
        .fsync_n_o(fs_n), .pu_en_o(pu_en), .expose_o(ex_i));

    // 250 MHz clock
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // Sample point clear of both edges' updates
    task automatic tick(input int n = 1);
        repeat (n) begin
            @(negedge ref_clk_i);
            #1;
        end
    endtask : tick

    // Reset long enough for the minimum pulse width
    task automatic do_reset(input sps_mode_e m);
        @(negedge ref_clk_i);
        rstn_i = 1'b0;
        mode_i = m;
        repeat (SPS_RST_MIN_CYC) @(negedge ref_clk_i);
        rstn_i = 1'b1;
    endtask : do_reset

    // Wait for a frame, then check its envelope, row strobes and data
    task automatic measure_frame(input int lim);
        int w, fv_n, rv_n, lead;
        w = 0;
        while (fv !== 1'b1 && w < lim) begin
            tick();
            w++;
        end
        `CHK("frame start", 1'b1, fv)
        fv_n = 0;
        rv_n = 0;
        lead = 0;
        while (fv === 1'b1 && fv_n < ROWS * SPS_ROW_CYCLES + 10) begin
            if (rv_n == 0 && rv === 1'b0) lead++;
            if (rv === 1'b1) begin
                rv_n++;
                `CHK("pixel", PIX, pix_o)
            end else `CHK("idle pixel", SPS_PIX_RST, pix_o)
            fv_n++;
            tick();
        end
        `CHK("fv to rv", SPS_FV_TO_RV, lead)
        `CHK("frame length", ROWS * SPS_ROW_CYCLES, fv_n)
        `CHK("row valid cycles", ROWS * SPS_ROW_PIXELS, rv_n)
        `CHK("rv after frame", 1'b0, rv)
    endtask : measure_frame

    // Master: pin directions, reset mid-exposure, exposure length, frame
    task automatic t_master();
        int w;
        do_reset(SPS_MODE_MASTER);
        `CHK("oe master", 3'h7, {fv_oe, rv_oe, ex_oe})
        tick(10);
        `CHK("expose early", 1'b1, ex_o)
        @(negedge ref_clk_i);
        rstn_i = 1'b0;
        tick();
        `CHK("outs in reset", 14'h0000, {pix_o, fv, rv, ex_o, stby})
        repeat (SPS_RST_MIN_CYC) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        tick();
        w = 0;
        while (ex_o === 1'b1 && w < 3000) begin
            w++;
            tick();
        end
        `CHK("expose length", SPS_EXP_ROWS * SPS_ROW_CYCLES, w)
        measure_frame(10);
        $display("test master done, fails %0d", n_fail);
    endtask : t_master

    // Snapshot: idle without trigger, one frame after the trigger
    task automatic t_snapshot();
        do_reset(SPS_MODE_SNAPSHOT);
        `CHK("oe snapshot", 3'h6, {fv_oe, rv_oe, ex_oe})
        tick(100);
        `CHK("no frame untriggered", 1'b0, fv)
        i_host.trigger();
        measure_frame(SPS_EXP_ROWS * SPS_ROW_CYCLES + 20);
        $display("test snapshot done, fails %0d", n_fail);
    endtask : t_snapshot

    // Slave: pins are inputs, sync pulse, held-low standby, floating pin
    task automatic t_slave();
        do_reset(SPS_MODE_SLAVE);
        `CHK("oe slave", 3'h0, {fv_oe, rv_oe, ex_oe})
        i_host.sync_pulse();
        tick(8);
        `CHK("no readout slave", 2'h0, {fv, rv})
        i_host.set_sync(1'b0);
        tick(8);
        `CHK("standby held", 1'b1, stby)
        i_host.set_sync(1'b1);
        tick(8);
        `CHK("standby released", 1'b0, stby)
        i_host.float_line(1'b1);
        tick(20);
        `CHK("floating sync", 1'b0, stby)
        i_host.float_line(1'b0);
        i_host.set_sync(1'b1);
        $display("test slave done, fails %0d", n_fail);
    endtask : t_slave

    // Counts line, verdict, end of run
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Watchdog well beyond the roughly 5700 cycles the tests need
    initial begin
        #(20000 * 4);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial begin
        t_master();
        t_snapshot();
        t_slave();
        finish_test();
    end
endmodule : tb_sps_pixel_port
